// >>> core/liu_alarm_regs.svh
`ifndef LIU_ALARM_REGS_SVH
`define LIU_ALARM_REGS_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_IRQ_EN        8'h00
`define OFS_LINE_STATUS   8'h04
`define OFS_IRQ_STATUS    8'h08
`define OFS_IRQ_CLEAR     8'h0c
`define OFS_LINE_CTRL     8'h10

// Field positions shared by status, irq status, clear and enable
`define BIT_DRIVE_MON     6
`define BIT_FIFO_LIM      5
`define BIT_CODE_VIOL     4
`define BIT_RESERVED      7

// Field position in the line control register
`define BIT_B8ZS_EN       0

// Reset values
`define RST_IRQ_EN        3'h0
`define RST_IRQ_STATUS    3'h0
`define RST_LINE_CTRL     1'h0

// Clock and line rates, and the bit period derived from them
`define CORE_CLK_KHZ      200000
`define LINE_RATE_KHZ     1544
`define BIT_PERIOD_CYC    (`CORE_CLK_KHZ / `LINE_RATE_KHZ)

// Alarm thresholds
`define DM_SILENT_BITS    128
`define FIFO_NEAR_BITS    3

// Jitter attenuator pointer width
`define JA_PTR_W          6

`endif

// >>> core/liu_alarm_pkg.sv
package liu_alarm_pkg;

    // AXI response codes used by the slave
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    // One byte of register data
    typedef logic [7:0] reg_byte_t;

endpackage

// >>> core/status_change_detect.sv
`timescale 1ns/1ps

// Flags a one-cycle change pulse for each bit whose level moved
module status_change_detect #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Watched levels and change pulses
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] change
);

    logic [W-1:0] prev_ff;  // Level seen one cycle earlier

    // Remember the previous level; reset matches the status reset value
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level;
        end
    end

    // Any difference from the last cycle is a transition
    assign change = level ^ prev_ff; // [R12]

endmodule // status_change_detect

// >>> core/liu_channel_alarm_status.sv
// Notes on behaviour
// [R1] Alarm after 128 silent transmit bit periods
// [R2] Any transmit pulse clears alarm at once
// [R3] Bit 6 reads live drive monitor alarm
// [R4] Enabled drive monitor change raises interrupt
// [R5] Bit 5 set while pointers within three
// [R6] Enabled FIFO limit change raises interrupt
// [R7] Bit 4 shows violation or B8ZS zeros
// [R8] Enabled violation change raises interrupt
// [R9] Software uses bit 4 only framer bypassed
// [R10] Interrupt enables reset to zero
// [R11] Software selects single rail on both
// [R12] Changes found by previous-cycle compare; bit7 zero
`timescale 1ns/1ps
`include "liu_alarm_regs.svh"

module liu_channel_alarm_status (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // AXI4-Lite write address channel
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    // AXI4-Lite write data channel
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // AXI4-Lite write response channel
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read address channel
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    // AXI4-Lite read data channel
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Transmit line output pair, from pins
    input  wire logic                  tx_line_positive,
    input  wire logic                  tx_line_negative,
    // Jitter attenuator pointers, same clock
    input  wire logic [`JA_PTR_W-1:0]  ja_wr_ptr,
    input  wire logic [`JA_PTR_W-1:0]  ja_rd_ptr,
    // Receiver code checks, same clock
    input  wire logic                  rx_code_violation,
    input  wire logic                  rx_excess_zeros,
    // Interrupt request
    output logic                       irq
);

    // Bit period count, cut to the divider width
    localparam logic [7:0] BIT_LAST = 8'(`BIT_PERIOD_CYC - 1);
    // Silent bit periods that declare the alarm
    localparam logic [7:0] DM_LIMIT = 8'(`DM_SILENT_BITS);
    // Pointer distance that counts as near
    localparam logic [`JA_PTR_W-1:0] NEAR_LIM =
        `JA_PTR_W'(`FIFO_NEAR_BITS);

    // Pin synchronisers
    logic        tx_pos_meta_ff;     // First stage, positive rail
    logic        tx_neg_meta_ff;     // First stage, negative rail
    logic        tx_pos_ff;          // Synchronised positive rail
    logic        tx_neg_ff;          // Synchronised negative rail
    logic        tx_activity;        // A pulse on either rail

    // Bit period divider and drive monitor
    logic [7:0]  bit_div_ff;         // Core cycles within a bit period
    logic        bit_tick;           // One pulse per line bit period
    logic [7:0]  silent_cnt_ff;      // Bit periods with no pulse
    logic        drive_monitor_alarm;
    logic        dm_alarm_ff;        // Drive monitor alarm state

    // FIFO limit and code violation levels
    logic [`JA_PTR_W-1:0] ptr_fwd;   // Write minus read
    logic [`JA_PTR_W-1:0] ptr_back;  // Read minus write
    logic        fifo_limit_flag;
    logic        fifo_lim_ff;        // Registered FIFO limit level
    logic        line_code_violation_flag;
    logic        lcv_ff;             // Registered violation level
    logic        b8zs_en_ff;         // Excess zeros count as violation

    // Interrupt state, bit 2 drive, 1 FIFO, 0 violation
    logic [2:0]  alarm_level;        // Live status levels
    logic [2:0]  alarm_change;       // Change pulses
    logic [2:0]  irq_status_ff;      // Sticky change bits
    logic [2:0]  irq_en_ff;          // Enables of the same layout
    logic [2:0]  irq_clear;          // Clear strobes from software
    logic        irq_ff;             // Registered interrupt line

    // Register images
    liu_alarm_pkg::reg_byte_t line_status;
    liu_alarm_pkg::reg_byte_t irq_status_byte;
    liu_alarm_pkg::reg_byte_t irq_en_byte;

    // Bus slave state
    logic        aw_held_ff;         // Write address captured
    logic [7:0]  aw_addr_ff;
    logic        w_held_ff;          // Write data captured
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        do_write;           // Both halves held, no response due
    logic        ar_take;            // Read address taken this cycle
    logic        wr_hit;             // Write address is mapped
    logic        wr_lane0;           // Low byte lane enabled

    // Two flip-flops on each transmit rail before any logic
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_pos_meta_ff <= 1'b0;
            tx_neg_meta_ff <= 1'b0;
            tx_pos_ff      <= 1'b0;
            tx_neg_ff      <= 1'b0;
        end else begin
            tx_pos_meta_ff <= tx_line_positive;
            tx_neg_meta_ff <= tx_line_negative;
            tx_pos_ff      <= tx_pos_meta_ff;
            tx_neg_ff      <= tx_neg_meta_ff;
        end
    end

    // A mark of either polarity is bipolar activity
    assign tx_activity = tx_pos_ff | tx_neg_ff;

    // Divider that marks each line bit period
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bit_div_ff <= 8'h00;
        end else if (bit_div_ff == BIT_LAST) begin
            bit_div_ff <= 8'h00;
        end else begin
            bit_div_ff <= bit_div_ff + 8'h01;
        end
    end

    assign bit_tick = (bit_div_ff == BIT_LAST);

    // Count silent bit periods; activity restarts the count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            silent_cnt_ff <= 8'h00;
        end else if (tx_activity) begin
            // Pulse seen, start over
            silent_cnt_ff <= 8'h00; // [R2]
        end else if (bit_tick && (silent_cnt_ff != DM_LIMIT)) begin
            // One more silent period, saturating at the limit
            silent_cnt_ff <= silent_cnt_ff + 8'h01; // [R1]
        end
    end

    // Declare at the limit, drop the moment a pulse shows
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            dm_alarm_ff <= 1'b0;
        end else if (tx_activity) begin
            // No further bit periods are awaited
            dm_alarm_ff <= 1'b0; // [R2]
        end else if (bit_tick && (silent_cnt_ff == DM_LIMIT - 8'h01)) begin
            // The limit-th silent period has just ended
            dm_alarm_ff <= 1'b1; // [R1]
        end
    end

    assign drive_monitor_alarm = dm_alarm_ff;

    // Pointer distance in both directions, modulo the pointer range
    assign ptr_fwd  = ja_wr_ptr - ja_rd_ptr;
    assign ptr_back = ja_rd_ptr - ja_wr_ptr;

    // Near when either distance is within the limit
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fifo_lim_ff <= 1'b0;
        end else begin
            fifo_lim_ff <= (ptr_fwd <= NEAR_LIM) ||
                           (ptr_back <= NEAR_LIM); // [R5]
        end
    end

    assign fifo_limit_flag = fifo_lim_ff;

    // Violation level, with excess zeros only in B8ZS mode
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lcv_ff <= 1'b0;
        end else begin
            lcv_ff <= rx_code_violation |
                      (b8zs_en_ff & rx_excess_zeros); // [R7]
        end
    end

    assign line_code_violation_flag = lcv_ff;

    // Live status byte; reserved and low bits read zero
    always_comb begin
        line_status = 8'h00; // [R12]
        line_status[`BIT_DRIVE_MON] = drive_monitor_alarm; // [R3]
        line_status[`BIT_FIFO_LIM]  = fifo_limit_flag;     // [R5]
        line_status[`BIT_CODE_VIOL] = line_code_violation_flag; // [R7]
    end

    // Gather the levels in interrupt order
    assign alarm_level = {drive_monitor_alarm, fifo_limit_flag,
                          line_code_violation_flag};

    // Transitions both ways on every status level
    status_change_detect #(
        .W      (3)
    ) u_change (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .level    (alarm_level),
        .change   (alarm_change)
    );

    // Clear strobes from the low lane of a clear write
    assign irq_clear = (do_write && wr_lane0 &&
                        (aw_addr_ff[7:2] == `OFS_IRQ_CLEAR >> 2)) ?
                       {w_data_ff[`BIT_DRIVE_MON],
                        w_data_ff[`BIT_FIFO_LIM],
                        w_data_ff[`BIT_CODE_VIOL]} : 3'h0;

    // Sticky change bits; a new change beats a clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_status_ff <= `RST_IRQ_STATUS;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) |
                             alarm_change; // [R4] [R6] [R8]
        end
    end

    // Interrupt line high while an enabled sticky bit stands
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_en_ff); // [R4] [R6] [R8]
        end
    end

    assign irq = irq_ff;

    // Register images for reads
    always_comb begin
        irq_status_byte = 8'h00;
        irq_status_byte[`BIT_DRIVE_MON] = irq_status_ff[2];
        irq_status_byte[`BIT_FIFO_LIM]  = irq_status_ff[1];
        irq_status_byte[`BIT_CODE_VIOL] = irq_status_ff[0];
        irq_en_byte = 8'h00;
        irq_en_byte[`BIT_DRIVE_MON] = irq_en_ff[2];
        irq_en_byte[`BIT_FIFO_LIM]  = irq_en_ff[1];
        irq_en_byte[`BIT_CODE_VIOL] = irq_en_ff[0];
    end

    // Write side handshakes: one write at a time
    assign awready  = !aw_held_ff && !bvalid_ff;
    assign wready   = !w_held_ff && !bvalid_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_lane0 = w_strb_ff[0];

    // Mapped write targets
    assign wr_hit = (aw_addr_ff[7:2] == `OFS_IRQ_EN >> 2)      ||
                    (aw_addr_ff[7:2] == `OFS_LINE_STATUS >> 2) ||
                    (aw_addr_ff[7:2] == `OFS_IRQ_STATUS >> 2)  ||
                    (aw_addr_ff[7:2] == `OFS_IRQ_CLEAR >> 2)   ||
                    (aw_addr_ff[7:2] == `OFS_LINE_CTRL >> 2);

    // Capture the write address when offered
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= awaddr;
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    // Capture the write data when offered
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    // Write response, held until the master takes it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= liu_alarm_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            // Unmapped addresses answer with an error
            bresp_ff  <= wr_hit ? liu_alarm_pkg::RESP_OKAY
                                : liu_alarm_pkg::RESP_SLVERR;
        end else if (bvalid_ff && bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Interrupt enables, off until software sets them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_en_ff <= `RST_IRQ_EN; // [R10]
        end else if (do_write && wr_lane0 &&
                     (aw_addr_ff[7:2] == `OFS_IRQ_EN >> 2)) begin
            irq_en_ff <= {w_data_ff[`BIT_DRIVE_MON], // [R4]
                          w_data_ff[`BIT_FIFO_LIM],  // [R6]
                          w_data_ff[`BIT_CODE_VIOL]}; // [R8]
        end
    end

    // Line control: B8ZS selection for excess zeros
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            b8zs_en_ff <= `RST_LINE_CTRL;
        end else if (do_write && wr_lane0 &&
                     (aw_addr_ff[7:2] == `OFS_LINE_CTRL >> 2)) begin
            b8zs_en_ff <= w_data_ff[`BIT_B8ZS_EN]; // [R7]
        end
    end

    // Read side: one read at a time
    assign arready = !rvalid_ff;
    assign ar_take = arvalid && arready;

    // Read data and response, held until the master takes them
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= liu_alarm_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= liu_alarm_pkg::RESP_OKAY;
            case (araddr[7:2])
                // Enable register
                `OFS_IRQ_EN >> 2: begin
                    rdata_ff <= {24'h00_0000, irq_en_byte};
                end
                // Live alarm status, read only
                `OFS_LINE_STATUS >> 2: begin
                    rdata_ff <= {24'h00_0000, line_status}; // [R3]
                end
                // Sticky change bits
                `OFS_IRQ_STATUS >> 2: begin
                    rdata_ff <= {24'h00_0000, irq_status_byte};
                end
                // Write-only clear reads zero
                `OFS_IRQ_CLEAR >> 2: begin
                    rdata_ff <= 32'h0000_0000;
                end
                // Line control
                `OFS_LINE_CTRL >> 2: begin
                    rdata_ff <= {31'h0000_0000, b8zs_en_ff};
                end
                // Unmapped address
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= liu_alarm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Bus outputs from their flip-flops
    assign bvalid = bvalid_ff;
    assign bresp  = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata  = rdata_ff;
    assign rresp  = rresp_ff;

endmodule // liu_channel_alarm_status

// >>> tb/liu_channel_alarm_status_props.sv
`timescale 1ns/1ps
`include "liu_alarm_regs.svh"

module liu_alarm_props (
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 sys_rst,
    // Register bus
    input wire logic [7:0]           awaddr,
    input wire logic                 awvalid,
    input wire logic                 awready,
    input wire logic [31:0]          wdata,
    input wire logic [3:0]           wstrb,
    input wire logic                 wvalid,
    input wire logic                 wready,
    input wire logic                 bvalid,
    input wire logic                 arvalid,
    input wire logic                 arready,
    input wire logic [31:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 rready,
    // Line side
    input wire logic                 tx_line_positive,
    input wire logic                 tx_line_negative,
    input wire logic [`JA_PTR_W-1:0] ja_wr_ptr,
    input wire logic [`JA_PTR_W-1:0] ja_rd_ptr,
    input wire logic                 rx_code_violation,
    input wire logic                 rx_excess_zeros,
    input wire logic                 irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    logic [2:0]            en_ff;  // Shadow of the interrupt enables
    logic [14:0]           sil_ff; // Cycles with no transmit mark
    logic [`JA_PTR_W-1:0]  d_wr;   // Write minus read pointer
    logic [`JA_PTR_W-1:0]  d_rd;   // Read minus write pointer
    logic                  near;   // Pointers within three bits
    logic                  en_wr;  // Enable write taken this edge

    assign d_wr = ja_wr_ptr - ja_rd_ptr;
    assign d_rd = ja_rd_ptr - ja_wr_ptr;
    assign near = (d_wr <= 6'h03) || (d_rd <= 6'h03);
    assign en_wr = awvalid && awready && wvalid && wready && wstrb[0]
                   && (awaddr[7:2] == 6'h00);

    // Track what software wrote to the enables
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            en_ff <= 3'h0;
        end else if (en_wr) begin
            en_ff <= wdata[6:4];
        end
    end

    // Count silent cycles on the transmit pair
    always_ff @(posedge core_clk) begin
        if (sys_rst || tx_line_positive || tx_line_negative) begin
            sil_ff <= 15'h0000;
        end else if (sil_ff != 15'h7fff) begin
            sil_ff <= sil_ff + 15'h0001;
        end
    end

    AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid)
        else $error("read answer missing");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    AST_B_ANSWER: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer missing");
    AST_RD_UPPER: assert property (rvalid |-> rdata[31:7] == 25'h0)
        else $error("reserved read bits set");
    AST_IRQ_MASKED: assert property (
        en_ff == 3'h0 && $past(en_ff) == 3'h0 && $past(en_ff, 2) == 3'h0
        && $past(en_ff, 3) == 3'h0 |-> !irq)
        else $error("interrupt while all disabled");
    AST_FIFO_IRQ: assert property (
        en_ff[1] && $past(en_ff[1], 3) && near != $past(near) |-> ##[1:4] irq)
        else $error("fifo limit change lost");
    AST_LCV_IRQ: assert property (
        en_ff[0] && $past(en_ff[0], 3) && $changed(rx_code_violation)
        && !rx_excess_zeros && $stable(rx_excess_zeros) |-> ##[1:4] irq)
        else $error("code violation change lost");
    AST_DM_IRQ: assert property (
        en_ff[2] && sil_ff > 15'd16700
        && (tx_line_positive || tx_line_negative) |-> ##[3:8] irq)
        else $error("drive monitor clear lost");
endmodule // liu_alarm_props

bind liu_channel_alarm_status liu_alarm_props u_props (
    .core_clk, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bvalid, .arvalid, .arready, .rdata, .rvalid,
    .rready, .tx_line_positive, .tx_line_negative, .ja_wr_ptr,
    .ja_rd_ptr, .rx_code_violation, .rx_excess_zeros, .irq
);

// >>> tb/t1_tx_line_model.sv
`timescale 1ns/1ps
`include "liu_alarm_regs.svh"

module t1_tx_line_model #(
    parameter int BIT_CYC  = `BIT_PERIOD_CYC, // Core cycles per line bit
    parameter int MARK_CYC = 4                // Width of one mark
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Bench control: send marks or go silent
    input wire logic active,
    // Transmit line pair
    output logic     tx_line_positive,
    output logic     tx_line_negative
);
    int   cnt_ff; // Position in the bit period
    logic pol_ff; // Rail of the next mark

    // Free bit period divider
    always_ff @(posedge core_clk) begin
        if (sys_rst || cnt_ff == BIT_CYC - 1) begin
            cnt_ff <= 0;
        end else begin
            cnt_ff <= cnt_ff + 1;
        end
    end

    // Alternate mark inversion, space when silent
    always_ff @(posedge core_clk) begin
        if (sys_rst || !active) begin
            tx_line_positive <= 1'b0;
            tx_line_negative <= 1'b0;
            pol_ff           <= 1'b0;
        end else if (cnt_ff == 0) begin
            tx_line_positive <= pol_ff;
            tx_line_negative <= !pol_ff;
            pol_ff           <= !pol_ff;
        end else if (cnt_ff == MARK_CYC) begin
            tx_line_positive <= 1'b0;
            tx_line_negative <= 1'b0;
        end
    end
endmodule // t1_tx_line_model

// >>> tb/liu_channel_alarm_status_bench.sv
`timescale 1ns/1ps
`include "liu_alarm_regs.svh"

module liu_channel_alarm_status_bench;
    // Clock, reset and bus
    logic        core_clk = 1'b0, sys_rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0, strb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    // Line side
    logic        tx_line_positive, tx_line_negative, line_on = 1'b1;
    logic [5:0]  ja_wr_ptr = 6'h00, ja_rd_ptr = 6'h20;
    logic        rx_code_violation = 1'b0, rx_excess_zeros = 1'b0;
    // Counters and model registers
    int          error_cnt = 0, checked = 0, cyc = 0;
    int          en_m = 0, ctrl_m = 0, stk_m = 0, st_m = 0, r, d;
    int          dl[8] = '{0, 3, 4, 61, 60, 1, 62, 32};

    always #2.5 core_clk = ~core_clk;

    liu_channel_alarm_status u_dut (.*);
    t1_tx_line_model u_line (.core_clk, .sys_rst, .active(line_on),
        .tx_line_positive, .tx_line_negative);

    // Compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Final report
    task automatic summarize;
        $display("mismatches %0d compares %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            summarize();
        end
    end

    // Bus write, handshakes judged mid-cycle
    task automatic wr(input logic [7:0] a, input int v, input logic [1:0] e);
        logic ha, hw;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge core_clk);
        while (awvalid || wvalid) begin
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge core_clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            @(negedge core_clk);
        end
        while (!bvalid) @(negedge core_clk);
        cmp(bresp, e);
        @(posedge core_clk);
        bready <= 1'b0;
    endtask

    // Bus read compared with the model
    task automatic chk(input logic [7:0] a);
        int e;
        e = (a == `OFS_IRQ_EN) ? en_m : (a == `OFS_LINE_STATUS) ? st_m :
            (a == `OFS_IRQ_STATUS) ? stk_m :
            (a == `OFS_LINE_CTRL) ? ctrl_m : 0;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        @(negedge core_clk);
        while (!arready) @(negedge core_clk);
        @(posedge core_clk);
        arvalid <= 1'b0;
        @(negedge core_clk);
        while (!rvalid) @(negedge core_clk);
        cmp(rdata, e);
        cmp(rresp, (a > 8'h10) ? 2'b10 : 2'b00);
        @(posedge core_clk);
        rready <= 1'b1;
        @(posedge core_clk);
        rready <= 1'b0;
    endtask

    // Write and update the model
    task automatic mw(input logic [7:0] a, input int v);
        wr(a, v, 2'b00);
        if (a == `OFS_IRQ_EN) en_m = v & 'h70;
        if (a == `OFS_IRQ_CLEAR) stk_m = stk_m & ~v;
        if (a == `OFS_LINE_CTRL) ctrl_m = v & 1;
    endtask

    // New live status; any change sets sticky bits
    function automatic void set_st(input int s);
        stk_m = stk_m | ((s ^ st_m) & 'h70);
        st_m = s;
    endfunction

    // Status, sticky and interrupt line together
    task automatic chk_all;
        chk(`OFS_LINE_STATUS);
        chk(`OFS_IRQ_STATUS);
        @(negedge core_clk);
        cmp(irq, (stk_m & en_m) != 0);
        mw(`OFS_IRQ_CLEAR, 'h70);
    endtask

    initial begin
        void'($urandom(32'hf38a));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        strb = 4'he;
        wr(`OFS_IRQ_EN, 'h70, 2'b00);
        strb = 4'hf;
        // Reset values and the unmapped word
        for (int a = 0; a <= 'h14; a += 4) chk(a[7:0]);
        wr(`OFS_LINE_STATUS, 'hff, 2'b00);
        wr(8'h18, 'hff, 2'b10);
        chk(`OFS_LINE_STATUS);
        repeat (4) begin
            mw(`OFS_IRQ_EN, $urandom);
            chk(`OFS_IRQ_EN);
        end
        // Pointer separation around the limit
        mw(`OFS_IRQ_EN, 'h20);
        for (int i = 0; i < 8; i++) begin
            r = $urandom % 64;
            d = dl[i];
            @(posedge core_clk);
            ja_rd_ptr <= r[5:0];
            ja_wr_ptr <= r[5:0] + d[5:0];
            repeat (4) @(posedge core_clk);
            set_st((d <= 3 || d >= 61) ? (st_m | 'h20) : (st_m & ~'h20));
            chk_all();
        end
        // Every violation, zeros and coding mix
        mw(`OFS_IRQ_EN, 'h10);
        for (int i = 0; i < 8; i++) begin
            mw(`OFS_LINE_CTRL, i >> 2);
            @(posedge core_clk);
            rx_code_violation <= i[0];
            rx_excess_zeros <= i[1];
            repeat (4) @(posedge core_clk);
            d = i[0] | (i[2] & i[1]);
            set_st(d ? (st_m | 'h10) : (st_m & ~'h10));
            chk_all();
            chk(`OFS_LINE_CTRL);
        end
        // Silent transmit line, then activity again
        mw(`OFS_IRQ_EN, 'h40);
        line_on <= 1'b0;
        repeat (125 * 129) @(posedge core_clk);
        chk(`OFS_LINE_STATUS);
        repeat (6 * 129) @(posedge core_clk);
        set_st(st_m | 'h40);
        chk_all();
        line_on <= 1'b1;
        do @(negedge core_clk);
        while (!(tx_line_positive || tx_line_negative));
        repeat (6) @(posedge core_clk);
        set_st(st_m & ~'h40);
        chk_all();
        summarize();
    end
endmodule // liu_channel_alarm_status_bench
